// ==== inc/gper_pkg.sv ====
// constants, register map and state layout of the gpio pin configuration block
// assumes a single 25 MHz clock and a byte-wide register port
package gper_pkg;

    localparam int NUM_PORTS     = 5;
    localparam int PINS_PER_PORT = 8;
    localparam int NUM_PINS      = NUM_PORTS * PINS_PER_PORT;

    // register offsets
    localparam logic [7:0] OFS_PIN_SELECT    = 8'hF0;
    localparam logic [7:0] OFS_PIN_CONFIG    = 8'hF1;
    localparam logic [7:0] OFS_EVENT_ROUTING = 8'hF2;
    localparam logic [7:0] OFS_PIN_DATA      = 8'hF3;
    localparam logic [7:0] OFS_MUX_CONTROL   = 8'hF4;

    // pin configuration fields
    localparam int BIT_OUT_EN   = 0;
    localparam int BIT_OUT_TYPE = 1;
    localparam int BIT_PULLUP   = 2;
    localparam int BIT_LOCK     = 3;
    localparam int BIT_EVT_TYPE = 4;
    localparam int BIT_EVT_POL  = 5;
    localparam int BIT_DEB_EN   = 6;

    // event routing fields
    localparam int BIT_ROUTE_IRQ = 0;
    localparam int BIT_ROUTE_SMI = 1;
    localparam int BIT_ROUTE_PWU = 2;

    // pin select fields, own data and mux registers
    localparam int SEL_PORT_LSB     = 4;
    localparam int SEL_PIN_LSB      = 0;
    localparam int BIT_DATA_OUT     = 0;
    localparam int BIT_DATA_IN      = 1;
    localparam int BIT_MUX_SEL      = 0;
    localparam int BIT_MUX_LOCK     = 7;

    // reset values
    localparam logic [7:0] RST_CFG_EVENT = 8'h44;
    localparam logic [7:0] RST_CFG_PLAIN = 8'h04;
    localparam logic [2:0] RST_ROUTING   = 3'h0;
    localparam logic [6:0] RST_SELECT    = 7'h00;

    // debounce period
    localparam int CLK_PERIOD_NS = 40;
    localparam int DEB_TIME_NS   = 16000;
    localparam int DEB_CYCLES    = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_W         = 9;

    typedef logic [NUM_PINS-1:0] gper_pins_t;

    typedef struct packed {
        logic [6:0]                        sel;
        logic [NUM_PINS-1:0][7:0]          cfg;
        logic [NUM_PINS-1:0][2:0]          route;
        gper_pins_t                        dout;
        gper_pins_t                        mux;
        logic                              mux_lock;
        gper_pins_t                        s1;
        gper_pins_t                        s2;
        gper_pins_t                        s3;
        gper_pins_t                        stable;
        gper_pins_t                        deb;
        gper_pins_t                        deb_prev;
        gper_pins_t                        evt;
        logic [NUM_PINS-1:0][DEB_W-1:0]    cnt;
        logic [7:0]                        rdata;
        gper_pins_t                        pin_out;
        gper_pins_t                        pin_oe;
        gper_pins_t                        pin_pu;
        gper_pins_t                        mux_out;
        logic                              irq;
        logic                              system_mgmt_interrupt;
        logic                              pwu;
    } gper_state_s;

endpackage

// ==== src/gper_pin_config.sv ====
// gpio pin configuration, lock and event routing for five ports of eight pins
// assumes pins arrive asynchronously and the register port is on SYS_CLK
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns

module gper_pin_config
    import gper_pkg::*;
(
    input  wire logic                SYS_CLK,
    input  wire logic                RST_N,
    input  wire logic [7:0]          ADDR,
    input  wire logic [7:0]          WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output      logic [7:0]          RDATA,
    input  wire logic [NUM_PINS-1:0] GPIO_IN,
    output      logic [NUM_PINS-1:0] GPIO_OUT,
    output      logic [NUM_PINS-1:0] GPIO_OE,
    output      logic [NUM_PINS-1:0] GPIO_PU,
    output      logic [NUM_PINS-1:0] MUX_SEL,
    output      logic                INT_REQ,
    output      logic                SYS_MGMT_INT,
    output      logic                POWER_WAKEUP_REQ
);

    // ports 0, 1 and 4 carry event detection
    function automatic logic has_events(input logic [2:0] port);
        return (port == 3'h0) || (port == 3'h1) || (port == 3'h4);
    endfunction

    // select field names an existing port
    function automatic logic sel_valid(input logic [6:0] sel);
        return sel[SEL_PORT_LSB +: 3] < 3'(NUM_PORTS);
    endfunction

    // state after reset, config value depends on port kind
    function automatic gper_state_s reset_state();
        gper_state_s s;
        s = '0;
        s.sel = RST_SELECT;
        // input path starts at the pulled-up idle level, so no false edge after reset
        s.s1       = '1;
        s.s2       = '1;
        s.s3       = '1;
        s.stable   = '1;
        s.deb      = '1;
        s.deb_prev = '1;
        for (int p = 0; p < NUM_PINS; p++)
        begin
            s.cfg[p]    = has_events(3'(p / PINS_PER_PORT)) ? RST_CFG_EVENT : RST_CFG_PLAIN;
            s.route[p]  = RST_ROUTING;
            s.pin_pu[p] = 1'b1;
        end
        return s;
    endfunction

    gper_state_s r_reg;
    gper_state_s r_next;

    // register access, pin sampling, event detection and pin drive
    always_comb
    begin
        logic [5:0] idx;
        logic       ok;
        logic       ev;
        logic       locked;
        logic       active;
        logic [7:0] rd_val;
        logic       irq_any;
        logic       smi_any;
        logic       pwu_any;
        idx     = '0;
        ok      = 1'b0;
        ev      = 1'b0;
        locked  = 1'b0;
        active  = 1'b0;
        rd_val  = '0;
        irq_any = 1'b0;
        smi_any = 1'b0;
        pwu_any = 1'b0;
        r_next  = r_reg;

        // selected pin from port and pin fields
        idx    = {r_reg.sel[SEL_PORT_LSB +: 3], r_reg.sel[SEL_PIN_LSB +: 3]};
        ok     = sel_valid(r_reg.sel);
        ev     = has_events(r_reg.sel[SEL_PORT_LSB +: 3]);
        locked = ok && r_reg.cfg[idx][BIT_LOCK];

        // register writes
        if (WR)
        begin
            if (ADDR == OFS_PIN_SELECT)
            begin
                r_next.sel = {WDATA[6:4], 1'b0, WDATA[2:0]};
            end
            else if (ADDR == OFS_PIN_CONFIG && ok)
            begin
                // event fields exist only on event ports
                r_next.cfg[idx][6:4] = ev ? WDATA[6:4] : 3'h0;
                if (!locked)
                begin
                    r_next.cfg[idx][2:0] = WDATA[2:0];
                end
                // lock only sets, software cannot clear it
                r_next.cfg[idx][BIT_LOCK] = r_reg.cfg[idx][BIT_LOCK] | WDATA[BIT_LOCK];
            end
            else if (ADDR == OFS_EVENT_ROUTING && ok && ev)
            begin
                r_next.route[idx] = WDATA[2:0];
            end
            else if (ADDR == OFS_PIN_DATA && ok && !locked)
            begin
                r_next.dout[idx] = WDATA[BIT_DATA_OUT];
            end
            else if (ADDR == OFS_MUX_CONTROL && !r_reg.mux_lock)
            begin
                if (ok)
                begin
                    r_next.mux[idx] = WDATA[BIT_MUX_SEL];
                end
                r_next.mux_lock = WDATA[BIT_MUX_LOCK];
            end
        end

        // read data, shown only in the cycle after the strobe
        if (ADDR == OFS_PIN_SELECT)
        begin
            rd_val = {1'b0, r_reg.sel};
        end
        else if (ADDR == OFS_PIN_CONFIG && ok)
        begin
            rd_val = r_reg.cfg[idx];
        end
        else if (ADDR == OFS_EVENT_ROUTING && ok && ev)
        begin
            rd_val = {5'h00, r_reg.route[idx]};
        end
        else if (ADDR == OFS_PIN_DATA && ok)
        begin
            rd_val[BIT_DATA_OUT] = r_reg.dout[idx];
            rd_val[BIT_DATA_IN]  = r_reg.stable[idx];
        end
        else if (ADDR == OFS_MUX_CONTROL)
        begin
            rd_val[BIT_MUX_SEL]  = ok && r_reg.mux[idx];
            rd_val[BIT_MUX_LOCK] = r_reg.mux_lock;
        end
        r_next.rdata = RD ? rd_val : 8'h00;

        // per pin sampling, debounce, detection and drive
        for (int p = 0; p < NUM_PINS; p++)
        begin
            // input path runs whatever the output enable says
            r_next.s1[p] = GPIO_IN[p];
            r_next.s2[p] = r_reg.s1[p];
            r_next.s3[p] = r_reg.s2[p];
            if (r_reg.s2[p] == r_reg.s3[p])
            begin
                r_next.stable[p] = r_reg.s3[p];
            end

            // debounce holds a change until it lasts the full period
            if (r_reg.cfg[p][BIT_DEB_EN] && r_reg.stable[p] != r_reg.deb[p])
            begin
                if (r_reg.cnt[p] == DEB_W'(DEB_CYCLES - 1))
                begin
                    r_next.deb[p] = r_reg.stable[p];
                    r_next.cnt[p] = '0;
                end
                else
                begin
                    r_next.cnt[p] = r_reg.cnt[p] + DEB_W'(1);
                end
            end
            else
            begin
                r_next.deb[p] = r_reg.stable[p];
                r_next.cnt[p] = '0;
            end
            r_next.deb_prev[p] = r_reg.deb[p];

            // polarity picks the active level, type picks edge or level
            active = r_reg.cfg[p][BIT_EVT_POL] ? r_reg.deb[p] : ~r_reg.deb[p];
            if (!has_events(3'(p / PINS_PER_PORT)))
            begin
                r_next.evt[p] = 1'b0;
            end
            else if (r_reg.cfg[p][BIT_EVT_TYPE])
            begin
                r_next.evt[p] = active;
            end
            else
            begin
                r_next.evt[p] = active && (r_reg.deb[p] != r_reg.deb_prev[p]);
            end

            // route each event to the requested outputs
            irq_any = irq_any | (r_reg.evt[p] & r_reg.route[p][BIT_ROUTE_IRQ]);
            smi_any = smi_any | (r_reg.evt[p] & r_reg.route[p][BIT_ROUTE_SMI]);
            pwu_any = pwu_any | (r_reg.evt[p] & r_reg.route[p][BIT_ROUTE_PWU]);

            // open-drain drives only low, push-pull drives both levels
            r_next.pin_oe[p]  = r_next.cfg[p][BIT_OUT_EN]
                                & (r_next.cfg[p][BIT_OUT_TYPE] | ~r_next.dout[p]);
            r_next.pin_out[p] = r_next.cfg[p][BIT_OUT_TYPE] & r_next.dout[p];
            r_next.pin_pu[p]  = r_next.cfg[p][BIT_PULLUP];
            r_next.mux_out[p] = r_next.mux[p];
        end
        r_next.irq = irq_any;
        r_next.system_mgmt_interrupt = smi_any;
        r_next.pwu = pwu_any;
    end

    // state register, pin lock and mux lock cleared only here
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            r_reg <= reset_state();
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the state register
    assign RDATA            = r_reg.rdata;
    assign GPIO_OUT         = r_reg.pin_out;
    assign GPIO_OE          = r_reg.pin_oe;
    assign GPIO_PU          = r_reg.pin_pu;
    assign MUX_SEL          = r_reg.mux_out;
    assign INT_REQ          = r_reg.irq;
    assign SYS_MGMT_INT     = r_reg.system_mgmt_interrupt;
    assign POWER_WAKEUP_REQ = r_reg.pwu;

endmodule // gper_pin_config

// ==== testbench/gper_pin_config_sva.sv ====
// assertions on the ports of the pin configuration block
// assumes binding into gper_pin_config, one clock domain
`timescale 1ns/1ns

module gper_pin_config_sva
    import gper_pkg::*;
(
    input wire logic                SYS_CLK,
    input wire logic                RST_N,
    input wire logic                WR,
    input wire logic                RD,
    input wire logic [7:0]          RDATA,
    input wire logic [NUM_PINS-1:0] GPIO_OUT,
    input wire logic [NUM_PINS-1:0] GPIO_OE,
    input wire logic [NUM_PINS-1:0] GPIO_PU,
    input wire logic [NUM_PINS-1:0] MUX_SEL,
    input wire logic                INT_REQ,
    input wire logic                SYS_MGMT_INT,
    input wire logic                POWER_WAKEUP_REQ
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    // pin controls move only at the edge that takes a write
    chk_oe_needs_wr: assert property ($past(RST_N) && $changed(GPIO_OE) |-> $past(WR))
        else $error("output enable moved without a write");
    chk_out_needs_wr: assert property ($past(RST_N) && $changed(GPIO_OUT) |-> $past(WR))
        else $error("output value moved without a write");
    chk_pu_needs_wr: assert property ($past(RST_N) && $changed(GPIO_PU) |-> $past(WR))
        else $error("pull-up moved without a write");
    chk_mux_needs_wr: assert property ($past(RST_N) && $changed(MUX_SEL) |-> $past(WR))
        else $error("mux select moved without a write");
    // read data only in the cycle after a read strobe
    chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside its cycle");
    // values right after reset
    chk_pull_reset: assert property ($rose(RST_N) |-> GPIO_PU == {NUM_PINS{1'b1}})
        else $error("pull-ups not on after reset");
    chk_drive_reset: assert property ($rose(RST_N) |-> GPIO_OE == '0 && GPIO_OUT == '0)
        else $error("driver active after reset");
    chk_evt_reset: assert property ($rose(RST_N) |-> !(INT_REQ || SYS_MGMT_INT || POWER_WAKEUP_REQ))
        else $error("event output active after reset");
endmodule // gper_pin_config_sva

bind gper_pin_config gper_pin_config_sva gper_pin_config_sva_i (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .WR(WR), .RD(RD), .RDATA(RDATA),
    .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE), .GPIO_PU(GPIO_PU), .MUX_SEL(MUX_SEL),
    .INT_REQ(INT_REQ), .SYS_MGMT_INT(SYS_MGMT_INT), .POWER_WAKEUP_REQ(POWER_WAKEUP_REQ));

// ==== testbench/gper_board.sv ====
// board model: pin levels from device drivers, test sources and pull-ups
// assumes open-drain drivers only ever pull low
`timescale 1ns/1ns

module gper_board
    import gper_pkg::*;
(
    input  wire logic       clk,
    input  wire gper_pins_t gpio_out,
    input  wire gper_pins_t gpio_oe,
    input  wire gper_pins_t gpio_pu,
    input  wire gper_pins_t ext_en,
    input  wire gper_pins_t ext_val,
    output      gper_pins_t gpio_in
);
    gper_pins_t float_pat = '0;

    // an undriven pin without pull-up wanders every cycle
    always @(posedge clk)
        float_pat <= ~float_pat;

    // device driver wins, then test source, then pull-up
    always_comb
        for (int i = 0; i < NUM_PINS; i++)
            gpio_in[i] = gpio_oe[i] ? gpio_out[i] : ext_en[i] ? ext_val[i]
                       : gpio_pu[i] ? 1'b1 : float_pat[i];
endmodule // gper_board

// ==== testbench/tb.sv ====
// self-checking bench for the pin configuration block
// assumes the board model and checker are compiled alongside
`timescale 1ns/1ns

module tb
    import gper_pkg::*;
;
    logic       sys_clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic       int_req, system_mgmt_interrupt, pwu;
    gper_pins_t gpio_in, gpio_out, gpio_oe, gpio_pu, mux_sel;
    gper_pins_t ext_en = '0, ext_val = '0;
    int         mismatches = 0, samples_checked = 0;

    always #20 sys_clk = ~sys_clk;

    gper_pin_config gper_pin_config_i (.SYS_CLK(sys_clk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .GPIO_IN(gpio_in),
        .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .GPIO_PU(gpio_pu), .MUX_SEL(mux_sel),
        .INT_REQ(int_req), .SYS_MGMT_INT(system_mgmt_interrupt), .POWER_WAKEUP_REQ(pwu));
    gper_board gper_board_i (.clk(sys_clk), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .gpio_pu(gpio_pu), .ext_en(ext_en), .ext_val(ext_val), .gpio_in(gpio_in));

    task automatic chk(input logic [39:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, exp);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        chk(rdata, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic pin(input int i, input logic e, v);
        @(posedge sys_clk);
        ext_en[i] <= e;
        ext_val[i] <= v;
    endtask
    task automatic wait_evt(input logic [2:0] exp);
        int n;
        n = 0;
        while ({pwu, system_mgmt_interrupt, int_req} === 3'h0 && n < 40)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk({pwu, system_mgmt_interrupt, int_req}, exp);
    endtask

    task automatic t_defaults;
        settle(1);
        chk(gpio_pu, '1);
        rd_chk(OFS_PIN_CONFIG, 8'h44);
        rd_chk(OFS_EVENT_ROUTING, 8'h00);
        rd_chk(8'h00, 8'h00);
        wr_reg(OFS_PIN_SELECT, 8'h20);
        rd_chk(OFS_PIN_CONFIG, 8'h04);
        wr_reg(OFS_PIN_CONFIG, 8'h17);
        rd_chk(OFS_PIN_CONFIG, 8'h07);
        wr_reg(OFS_EVENT_ROUTING, 8'h07);
        rd_chk(OFS_EVENT_ROUTING, 8'h00);
        $display("test defaults done");
    endtask
    task automatic t_drive;
        wr_reg(OFS_PIN_SELECT, 8'h13);
        wr_reg(OFS_PIN_CONFIG, 8'h01);
        settle(2);
        chk(gpio_oe, 40'h00_0001_0800);
        wr_reg(OFS_PIN_DATA, 8'h01);
        settle(2);
        chk({gpio_oe[11], gpio_out[11]}, 2'b00);
        wr_reg(OFS_PIN_CONFIG, 8'h07);
        settle(2);
        chk({gpio_oe[11], gpio_out[11]}, 2'b11);
        settle(4);
        rd_chk(OFS_PIN_DATA, 8'h03);
        pin(11, 1'b1, 1'b0);
        wr_reg(OFS_PIN_CONFIG, 8'h04);
        settle(2);
        chk(gpio_oe[11], 1'b0);
        settle(4);
        rd_chk(OFS_PIN_DATA, 8'h01);
        $display("test drive done");
    endtask
    task automatic t_lock;
        pin(11, 1'b0, 1'b0);
        wr_reg(OFS_PIN_CONFIG, 8'h0F);
        wr_reg(OFS_PIN_CONFIG, 8'h00);
        wr_reg(OFS_PIN_DATA, 8'h00);
        rd_chk(OFS_PIN_CONFIG, 8'h0F);
        rd_chk(OFS_PIN_DATA, 8'h03);
        chk({gpio_oe[11], gpio_out[11], gpio_pu[11]}, 3'b111);
        wr_reg(OFS_MUX_CONTROL, 8'h01);
        settle(2);
        chk(mux_sel[11], 1'b1);
        wr_reg(OFS_MUX_CONTROL, 8'h81);
        wr_reg(OFS_MUX_CONTROL, 8'h00);
        settle(2);
        chk(mux_sel[11], 1'b1);
        $display("test lock done");
    endtask
    task automatic t_events;
        int r;
        logic seen;
        wr_reg(OFS_PIN_SELECT, 8'h01);
        wr_reg(OFS_PIN_CONFIG, 8'h24);
        pin(1, 1'b1, 1'b0);
        for (r = 1; r < 8; r = r * 2)
        begin
            wr_reg(OFS_EVENT_ROUTING, r[7:0]);
            settle(10);
            pin(1, 1'b1, 1'b1);
            wait_evt(r[2:0]);
            settle(1);
            chk({pwu, system_mgmt_interrupt, int_req}, 3'h0);
            pin(1, 1'b1, 1'b0);
        end
        wr_reg(OFS_PIN_CONFIG, 8'h34);
        wr_reg(OFS_EVENT_ROUTING, 8'h01);
        settle(10);
        pin(1, 1'b1, 1'b1);
        wait_evt(3'h1);
        settle(20);
        chk(int_req, 1'b1);
        pin(1, 1'b1, 1'b0);
        settle(15);
        chk(int_req, 1'b0);
        // debounced rising edge: nothing for DEB_CYCLES - 20 cycles, then the event
        wr_reg(OFS_PIN_CONFIG, 8'h64);
        settle(10);
        pin(1, 1'b1, 1'b1);
        seen = 1'b0;
        repeat (DEB_CYCLES - 20)
        begin
            @(negedge sys_clk);
            seen = seen | int_req;
        end
        chk(seen, 1'b0);
        wait_evt(3'h1);
        $display("test events done");
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_defaults;
        t_drive;
        t_lock;
        t_events;
        give_verdict;
    end

    // watchdog well beyond the expected run
    initial
    begin
        #400000;
        mismatches++;
        give_verdict;
    end
endmodule // tb
